// [design/spsel_pkg.sv]
package spsel_pkg;

    // ------------------------------------------------------------
    // select mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
    localparam int SEL_OUT_BIT = 1;
    localparam int SEL_LEVEL_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_SELECT_MODE = 2'h1;
    localparam logic RST_PORT_ENABLE = 1'h0;
    localparam logic RST_MASTER_ENABLE = 1'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] LAST_BIT_COUNT = 4'h8;
    localparam logic [3:0] SLAVE_LAST_RISE = 4'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // synchronised pin vector positions
    // ------------------------------------------------------------
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SEL = 3;
    localparam int PIN_COUNT = 4;

    typedef struct packed {
        logic port_en;
        logic master;
        logic [1:0] mode;
        logic xfer;
        logic sck;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic sample;
        logic [7:0] rx;
        logic done;
        logic fault;
        logic [3:0] prev;
        logic sck_o;
        logic sck_oen;
        logic mosi_o;
        logic mosi_oen;
        logic miso_o;
        logic miso_oen;
        logic sel_o;
        logic sel_oen;
        logic routed;
    } spsel_state_t;

endpackage : spsel_pkg

// [design/spsel_sync.sv]
module spsel_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : spsel_sync

// [design/spsel_clkdiv.sv]
module spsel_clkdiv #(
    parameter int HALF_CYCLES = 4
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic run_in,
    output logic tick_out
);

    localparam int CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic tick_q;

    // counter restarts whenever the transfer is idle, so the first half period is full length
    always_ff @(posedge clock_in)
    begin
        if (rst_in || !run_in)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick_out = tick_q;

endmodule : spsel_clkdiv

// [design/spsel_top.sv]
// Contract
// - as master, mosi carries the shift register msb in 3- and 4-wire form.
// - every byte moves msb first on both data lines.
// - mosi is driven as master and an input as slave.
// - miso is an input as master and driven as slave.
// - miso floats when the port is off or a 4-wire slave is unselected.
// - a 3-wire slave always drives miso from the shift register msb.
// - master makes sck itself; a slave takes sck from outside.
// - a 4-wire slave ignores sck while the select line is high.
// - mode 00 is 3-wire, select unused, slave always selected.
// - mode 01 is 4-wire with select as input, low selects a slave.
// - master in mode 01 drops mastership on a falling select input.
// - mode 1x drives the select line, level equals the low mode bit.
// - select is routed to a pin in every mode except 00.
// - mode fault clears master and port enables and sets the fault flag.
// - slave counts eight bits, then sets done and stores the byte.
// - a 4-wire slave clears its bit counter on a falling select.
module spsel_top #(
    parameter int SCK_HALF = spsel_pkg::SCK_HALF_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ctrl_wr_in,
    input wire logic ctrl_port_enable_in,
    input wire logic ctrl_master_enable_in,
    input wire logic [1:0] select_mode_field_in,
    input wire logic tx_wr_in,
    input wire logic [7:0] tx_data_in,
    input wire logic done_clr_in,
    input wire logic fault_clr_in,
    input wire logic sck_pin_in,
    input wire logic mosi_pin_in,
    input wire logic miso_pin_in,
    input wire logic slave_select_line_in,
    output logic sck_out,
    output logic sck_oe_n_out,
    output logic mosi_out,
    output logic mosi_oe_n_out,
    output logic miso_out,
    output logic miso_oe_n_out,
    output logic slave_select_line_out,
    output logic slave_select_line_oe_n_out,
    output logic select_routed_out,
    output logic port_enable_bit_out,
    output logic master_enable_bit_out,
    output logic transfer_done_flag_out,
    output logic mode_fault_flag_out,
    output logic busy_out,
    output logic [7:0] rx_data_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic slave_selected(input logic [1:0] mode, input logic sel_level);
        // mode 1x as slave has no select input; treated as selected
        slave_selected = (mode == spsel_pkg::SEL_4WIRE_IN) ? !sel_level : 1'b1;
    endfunction : slave_selected

    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
        shift_in = {cur[6:0], bit_in};
    endfunction : shift_in

    // ------------------------------------------------------------
    // pin synchronisers and sck divider
    // ------------------------------------------------------------
    spsel_pkg::spsel_state_t q;
    spsel_pkg::spsel_state_t d;
    logic [spsel_pkg::PIN_COUNT-1:0] pins_s;
    logic tick;

    // sync is kept in master mode too, so miso sampling is metastability safe
    spsel_sync #(
        .WIDTH(spsel_pkg::PIN_COUNT)
    ) u_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .async_in({slave_select_line_in, miso_pin_in, mosi_pin_in, sck_pin_in}),
        .sync_out(pins_s)
    );

    spsel_clkdiv #(
        .HALF_CYCLES(SCK_HALF)
    ) u_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .run_in(q.xfer),
        .tick_out(tick)
    );

    logic sck_rise;
    logic sck_fall;
    logic sel_fall;
    logic sel_s;
    logic slave_act;
    logic fault_evt;

    assign sel_s = pins_s[spsel_pkg::PIN_SEL];
    assign sck_rise = pins_s[spsel_pkg::PIN_SCK] && !q.prev[spsel_pkg::PIN_SCK];
    assign sck_fall = !pins_s[spsel_pkg::PIN_SCK] && q.prev[spsel_pkg::PIN_SCK];
    assign sel_fall = !sel_s && q.prev[spsel_pkg::PIN_SEL];
    assign slave_act = q.port_en && !q.master;
    assign fault_evt = q.port_en && q.master && q.mode == spsel_pkg::SEL_4WIRE_IN && sel_fall;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.mode = select_mode_field_in;
        d.prev = pins_s;
        if (done_clr_in)
        begin
            d.done = 1'b0;
        end
        if (fault_clr_in)
        begin
            d.fault = 1'b0;
        end
        if (ctrl_wr_in)
        begin
            d.port_en = ctrl_port_enable_in;
            d.master = ctrl_master_enable_in;
        end
        if (!q.port_en)
        begin
            // the only way to realign a 3-wire slave bit counter
            d.xfer = 1'b0;
            d.sck = 1'b0;
            d.cnt = '0;
        end
        else if (q.master)
        begin
            if (tx_wr_in && !q.xfer)
            begin
                d.shift = tx_data_in;
                d.xfer = 1'b1;
                d.cnt = '0;
            end
            else if (q.xfer && tick)
            begin
                if (!q.sck)
                begin
                    d.sck = 1'b1;
                    d.sample = pins_s[spsel_pkg::PIN_MISO];
                    d.cnt = q.cnt + 4'h1;
                end
                else
                begin
                    d.sck = 1'b0;
                    d.shift = shift_in(q.shift, q.sample);
                    if (q.cnt == spsel_pkg::LAST_BIT_COUNT)
                    begin
                        d.xfer = 1'b0;
                        d.done = 1'b1;
                        d.rx = shift_in(q.shift, q.sample);
                    end
                end
            end
        end
        else
        begin
            if (q.mode == spsel_pkg::SEL_4WIRE_IN && sel_fall)
            begin
                d.cnt = '0;
            end
            else if (slave_selected(q.mode, sel_s))
            begin
                if (sck_rise)
                begin
                    d.sample = pins_s[spsel_pkg::PIN_MOSI];
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == spsel_pkg::SLAVE_LAST_RISE)
                    begin
                        d.done = 1'b1;
                        d.rx = shift_in(q.shift, pins_s[spsel_pkg::PIN_MOSI]);
                        d.shift = shift_in(q.shift, pins_s[spsel_pkg::PIN_MOSI]);
                        d.cnt = '0;
                    end
                end
                else if (sck_fall && q.cnt != 4'h0)
                begin
                    d.shift = shift_in(q.shift, q.sample);
                end
                else if (tx_wr_in && q.cnt == 4'h0)
                begin
                    d.shift = tx_data_in;
                end
            end
        end
        if (fault_evt)
        begin
            // fault overrides a same-cycle control write
            d.port_en = 1'b0;
            d.master = 1'b0;
            d.fault = 1'b1;
            d.xfer = 1'b0;
            d.sck = 1'b0;
        end
        // pin drivers follow the current state one cycle later
        d.mosi_o = q.shift[7];
        d.mosi_oen = !(q.port_en && q.master);
        d.sck_o = q.sck;
        d.sck_oen = !(q.port_en && q.master);
        d.miso_o = q.shift[7];
        d.miso_oen = !(slave_act && slave_selected(q.mode, sel_s));
        d.sel_o = q.mode[spsel_pkg::SEL_OUT_BIT] ? q.mode[spsel_pkg::SEL_LEVEL_BIT] : 1'b1;
        d.sel_oen = !q.mode[spsel_pkg::SEL_OUT_BIT];
        d.routed = q.mode != spsel_pkg::SEL_3WIRE;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            q <= '0;
            q.port_en <= spsel_pkg::RST_PORT_ENABLE;
            q.master <= spsel_pkg::RST_MASTER_ENABLE;
            q.mode <= spsel_pkg::RST_SELECT_MODE;
            q.shift <= spsel_pkg::RST_BYTE;
            q.rx <= spsel_pkg::RST_BYTE;
            q.sck_oen <= 1'b1;
            q.mosi_oen <= 1'b1;
            q.miso_oen <= 1'b1;
            q.sel_o <= 1'b1;
            q.sel_oen <= 1'b1;
            q.routed <= spsel_pkg::RST_SELECT_MODE != spsel_pkg::SEL_3WIRE;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sck_out = q.sck_o;
    assign sck_oe_n_out = q.sck_oen;
    assign mosi_out = q.mosi_o;
    assign mosi_oe_n_out = q.mosi_oen;
    assign miso_out = q.miso_o;
    assign miso_oe_n_out = q.miso_oen;
    assign slave_select_line_out = q.sel_o;
    assign slave_select_line_oe_n_out = q.sel_oen;
    assign select_routed_out = q.routed;
    assign port_enable_bit_out = q.port_en;
    assign master_enable_bit_out = q.master;
    assign transfer_done_flag_out = q.done;
    assign mode_fault_flag_out = q.fault;
    assign busy_out = q.xfer;
    assign rx_data_out = q.rx;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_master_fall;
        q.xfer && tick && q.sck;
    endsequence

    sequence s_slave_last_rise;
        slave_act && slave_selected(q.mode, sel_s) && !(q.mode == spsel_pkg::SEL_4WIRE_IN && sel_fall)
            && sck_rise && q.cnt == spsel_pkg::SLAVE_LAST_RISE && !fault_evt;
    endsequence

    property p_mosi_msb;
        (q.port_en && q.master) ##1 1'b1 |-> mosi_out == $past(q.shift[7]) && !mosi_oe_n_out;
    endproperty
    a_mosi_msb: assert property (p_mosi_msb) else $error("mosi not msb");

    property p_msb_first;
        s_master_fall and (q.cnt != spsel_pkg::LAST_BIT_COUNT) && !fault_evt && q.port_en
            |=> q.shift[7] == $past(q.shift[6]) ##1 mosi_out == $past(q.shift[6], 2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("shift not msb first");

    property p_mosi_dir;
        !q.master ##1 1'b1 |-> mosi_oe_n_out && sck_oe_n_out;
    endproperty
    a_mosi_dir: assert property (p_mosi_dir) else $error("slave drives mosi or sck");

    property p_miso_dir;
        q.master ##1 1'b1 |-> miso_oe_n_out;
    endproperty
    a_miso_dir: assert property (p_miso_dir) else $error("master drives miso");

    property p_miso_float;
        (!q.port_en || (q.mode == spsel_pkg::SEL_4WIRE_IN && sel_s)) |=> miso_oe_n_out;
    endproperty
    a_miso_float: assert property (p_miso_float) else $error("miso not floated");

    property p_miso_3w;
        slave_act && q.mode == spsel_pkg::SEL_3WIRE |=> !miso_oe_n_out && miso_out == $past(q.shift[7]);
    endproperty
    a_miso_3w: assert property (p_miso_3w) else $error("3-wire slave miso wrong");

    property p_sck_gen;
        q.port_en && q.master |=> !sck_oe_n_out ##1 sck_out == $past(q.sck);
    endproperty
    a_sck_gen: assert property (p_sck_gen) else $error("master sck not driven");

    property p_ignore_sck;
        slave_act && q.mode == spsel_pkg::SEL_4WIRE_IN && sel_s && !ctrl_wr_in && !done_clr_in
            |=> $stable(q.cnt) && $stable(q.done);
    endproperty
    a_ignore_sck: assert property (p_ignore_sck) else $error("unselected slave counted");

    property p_fault;
        fault_evt |=> !q.port_en && !q.master && q.fault && !q.xfer ##2 mode_fault_flag_out && sck_oe_n_out;
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault not handled");

    property p_sel_out;
        q.mode[spsel_pkg::SEL_OUT_BIT] |=> !slave_select_line_oe_n_out
            && slave_select_line_out == $past(q.mode[spsel_pkg::SEL_LEVEL_BIT]);
    endproperty
    a_sel_out: assert property (p_sel_out) else $error("select output wrong");

    property p_routed;
        1'b1 |=> select_routed_out == ($past(q.mode) != spsel_pkg::SEL_3WIRE);
    endproperty
    a_routed: assert property (p_routed) else $error("select routing wrong");

    property p_slave_done;
        s_slave_last_rise |=> q.done && q.cnt == 4'h0 && q.rx[0] == $past(pins_s[spsel_pkg::PIN_MOSI])
            && q.rx[7:1] == $past(q.shift[6:0]) ##1 transfer_done_flag_out;
    endproperty
    a_slave_done: assert property (p_slave_done) else $error("slave byte not completed");

    property p_cnt_reset;
        slave_act && q.mode == spsel_pkg::SEL_4WIRE_IN && sel_fall && !ctrl_wr_in |=> q.cnt == 4'h0;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("bit counter not reset");

endmodule : spsel_top

// [verif/spsel_peer.sv]
module spsel_peer (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic mosi_out,
    output logic miso_out,
    output logic sel_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] reply_q;
    logic [7:0] got_q;
    logic serve_q;
    initial
    begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        miso_out = 1'b0;
        sel_n_out = 1'b1;
        serve_q = 1'b0;
        got_q = 8'h00;
    end
    // ------
    // slave side: sample at rise, shift at fall
    // ------
    always @(posedge sck_in)
    begin
        if (serve_q)
            got_q = {got_q[6:0], mosi_in};
    end
    always @(negedge sck_in)
    begin
        if (serve_q)
        begin
            reply_q = {reply_q[6:0], 1'b0};
            miso_out = reply_q[7];
        end
    end
    // only slave on the bus while serving
    task serve(input logic [7:0] b);
        reply_q = b;
        got_q = 8'h00;
        miso_out = b[7];
        serve_q = 1'b1;
    endtask : serve
    // released line shows the inverse so a stale bit cannot pass
    task quit;
        serve_q = 1'b0;
        miso_out = ~miso_out;
    endtask : quit
    task select(input logic lvl);
        sel_n_out = lvl;
    endtask : select
    // ------
    // master side: 200 ns clock, idle low between frames
    // ------
    task send(input logic [7:0] b, input int bits);
        got_q = 8'h00;
        #250;
        for (int i = 7; i > 7 - bits; i--)
        begin
            mosi_out = b[i];
            #100 sck_out = 1'b1;
            got_q = {got_q[6:0], miso_in};
            #100 sck_out = 1'b0;
        end
        #250 mosi_out = ~mosi_out;
    endtask : send
endmodule : spsel_peer

// [verif/spsel_pin_and_select_modes_bench.sv]
module spsel_pin_and_select_modes_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] mode;
        logic oe_n;
        logic lvl;
        logic routed;
    } spsel_row_t;
    // master rows: mode, select oe_n, select level, routed
    localparam logic [4:0] ROWS [4] = '{5'h06, 5'h0F, 5'h11, 5'h1B};
    // slave rows: mode, select level, byte expected
    localparam logic [3:0] SROWS [3] = '{4'h5, 4'h3, 4'h6};
    logic clock_in, rst_in, ctrl_wr, ctrl_pe, ctrl_me, tx_wr, done_clr, fault_clr;
    logic [1:0] mode;
    logic [7:0] tx_data;
    logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, sel_o, sel_oe_n;
    logic routed, pe, me, done, fault, busy;
    logic [7:0] rx;
    logic p_sck, p_mosi, p_miso, p_sel;
    wire logic sck_w, mosi_w, miso_w, sel_w;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // ------
    // pin resolution
    // ------
    assign sck_w = sck_oe_n ? p_sck : sck_o;
    assign mosi_w = mosi_oe_n ? p_mosi : mosi_o;
    assign miso_w = miso_oe_n ? p_miso : miso_o;
    assign sel_w = sel_oe_n ? p_sel : sel_o;
    spsel_top #(.SCK_HALF(4)) DUT (.clock_in(clock_in), .rst_in(rst_in), .ctrl_wr_in(ctrl_wr),
        .ctrl_port_enable_in(ctrl_pe), .ctrl_master_enable_in(ctrl_me), .select_mode_field_in(mode),
        .tx_wr_in(tx_wr), .tx_data_in(tx_data), .done_clr_in(done_clr), .fault_clr_in(fault_clr),
        .sck_pin_in(sck_w), .mosi_pin_in(mosi_w), .miso_pin_in(miso_w), .slave_select_line_in(sel_w),
        .sck_out(sck_o), .sck_oe_n_out(sck_oe_n), .mosi_out(mosi_o), .mosi_oe_n_out(mosi_oe_n),
        .miso_out(miso_o), .miso_oe_n_out(miso_oe_n), .slave_select_line_out(sel_o),
        .slave_select_line_oe_n_out(sel_oe_n), .select_routed_out(routed), .port_enable_bit_out(pe),
        .master_enable_bit_out(me), .transfer_done_flag_out(done), .mode_fault_flag_out(fault),
        .busy_out(busy), .rx_data_out(rx));
    spsel_peer peer (.sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w), .sck_out(p_sck),
        .mosi_out(p_mosi), .miso_out(p_miso), .sel_n_out(p_sel));
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // a hang counts as a mismatch
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run;
        end
    end
    // ------
    // helpers: inputs move at rising edges, checks at falling edges
    // ------
    task check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(negedge clock_in);
    endtask : tick
    task ctrl(input logic p, input logic m);
        @(posedge clock_in);
        ctrl_wr <= 1'b1;
        ctrl_pe <= p;
        ctrl_me <= m;
        @(posedge clock_in);
        ctrl_wr <= 1'b0;
        tick(2);
    endtask : ctrl
    task set_mode(input logic [1:0] m);
        @(posedge clock_in);
        mode <= m;
        tick(5);
    endtask : set_mode
    task wr_tx(input logic [7:0] b);
        @(posedge clock_in);
        tx_wr <= 1'b1;
        tx_data <= b;
        @(posedge clock_in);
        tx_wr <= 1'b0;
        tick(1);
    endtask : wr_tx
    task clear_flags(input logic dc, input logic fc);
        @(posedge clock_in);
        done_clr <= dc;
        fault_clr <= fc;
        @(posedge clock_in);
        done_clr <= 1'b0;
        fault_clr <= 1'b0;
        tick(2);
    endtask : clear_flags
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300)
        begin
            tick(1);
            n++;
        end
        check(busy === 1'b0, "busy stuck");
    endtask : wait_idle
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    // ------
    // main sequence
    // ------
    initial
    begin
        spsel_row_t row;
        logic [3:0] srow;
        rst_in = 1'b1;
        ctrl_wr = 1'b0;
        ctrl_pe = 1'b0;
        ctrl_me = 1'b0;
        mode = 2'h1;
        tx_wr = 1'b0;
        tx_data = 8'h00;
        done_clr = 1'b0;
        fault_clr = 1'b0;
        tick(12);
        @(posedge clock_in);
        rst_in <= 1'b0;
        tick(1);
        check({sck_oe_n, mosi_oe_n, miso_oe_n, sel_oe_n, sel_o, routed} === 6'h3F, "reset pins");
        check({pe, me, done, fault, busy} === 5'h00 && rx === 8'h00, "reset regs");
        ctrl(1'b1, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            row = spsel_row_t'(ROWS[i]);
            set_mode(row.mode);
            check({sel_oe_n, sel_o, routed} === {row.oe_n, row.lvl, row.routed}, "select pin");
            check({sck_oe_n, mosi_oe_n, miso_oe_n} === 3'h1, "master pins");
        end
        for (int i = 0; i < 2; i++)
        begin
            set_mode(i == 0 ? 2'h0 : 2'h2);
            peer.serve(i == 0 ? 8'h3C : 8'h01);
            wr_tx(i == 0 ? 8'hA5 : 8'h81);
            check(busy === 1'b1, "no start");
            wait_idle;
            check(done === 1'b1 && rx === (i == 0 ? 8'h3C : 8'h01), "master rx");
            check(peer.got_q === (i == 0 ? 8'hA5 : 8'h81), "mosi byte");
            peer.quit;
            clear_flags(1'b1, 1'b0);
            check(done === 1'b0 && fault === 1'b0, "done clear");
        end
        ctrl(1'b1, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            srow = SROWS[i];
            set_mode(srow[3:2]);
            peer.select(srow[1]);
            tick(4);
            wr_tx(8'hC3);
            tick(4);
            check(miso_oe_n === !srow[0], "miso enable");
            peer.send(8'h5A, 8);
            tick(6);
            check(done === srow[0], "slave done");
            if (srow[0])
                check(rx === 8'h5A && peer.got_q === 8'hC3, "slave byte");
            clear_flags(1'b1, 1'b0);
            peer.select(1'b1);
        end
        set_mode(2'h1);
        peer.select(1'b0);
        peer.send(8'hFF, 3);
        peer.select(1'b1);
        tick(4);
        check(done === 1'b0, "partial byte");
        peer.select(1'b0);
        peer.send(8'h69, 8);
        tick(6);
        check(done === 1'b1 && rx === 8'h69, "count restart");
        clear_flags(1'b1, 1'b0);
        peer.select(1'b1);
        ctrl(1'b0, 1'b0);
        set_mode(2'h0);
        check({sck_oe_n, mosi_oe_n, miso_oe_n} === 3'h7, "disabled pins");
        set_mode(2'h1);
        ctrl(1'b1, 1'b1);
        check(me === 1'b1, "master on");
        peer.select(1'b0);
        tick(6);
        check({pe, me, fault} === 3'h1 && sck_oe_n === 1'b1, "fault");
        peer.select(1'b1);
        clear_flags(1'b0, 1'b1);
        check(fault === 1'b0, "fault clear");
        @(posedge clock_in);
        rst_in <= 1'b1;
        tick(4);
        check(rx === 8'h00 && {pe, me, routed, sel_oe_n} === 4'h3, "mid reset");
        @(posedge clock_in);
        rst_in <= 1'b0;
        tick(4);
        check(routed === 1'b1 && miso_oe_n === 1'b1, "after reset");
        complete_run;
    end
endmodule : spsel_pin_and_select_modes_bench
